// >>> core/cegu_pkg.sv
`default_nettype none

package cegu_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] GAIN_UPDATE_STYLE_CONFIG_OFS = 8'h71;
  localparam logic [7:0] INPUT_CHANNEL_GATE_OFS       = 8'h73;
  localparam logic [7:0] OUTPUT_SLOT_GATE_OFS         = 8'h74;
  localparam logic [7:0] POWER_CONTROL_OFS            = 8'h75;

  localparam logic [7:0] GAIN_UPDATE_STYLE_CONFIG_RST = 8'h00;
  localparam logic [7:0] INPUT_CHANNEL_GATE_RST       = 8'hC0;
  localparam logic [7:0] OUTPUT_SLOT_GATE_RST         = 8'h00;
  localparam logic [7:0] POWER_CONTROL_RST            = 8'h00;

  // Writable masks; every other bit is held at its reset value.
  localparam logic [7:0] GAIN_UPDATE_STYLE_WMASK = 8'hC0;
  localparam logic [7:0] CHANNEL_GATE_WMASK      = 8'hF0;
  localparam logic [7:0] POWER_CONTROL_WMASK     = 8'h40;

  // Field positions.
  localparam int STYLE_LSB      = 6;
  localparam int LANE_LSB       = 4;
  localparam int POWER_UP_BIT   = 6;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ         = 50;
  localparam int STEP_FAST_US    = 20;
  localparam int STEP_SLOW_US    = 40;
  localparam int STEP_FAST_CYC   = STEP_FAST_US * CLK_MHZ;
  localparam int STEP_SLOW_CYC   = STEP_SLOW_US * CLK_MHZ;
  localparam int SMOOTH_CYC      = 8;
  localparam int GAIN_W          = 7;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CEGU_STYLE_IMMEDIATE,
    CEGU_STYLE_SMOOTH,
    CEGU_STYLE_RAMP_FAST,
    CEGU_STYLE_RAMP_SLOW
  } cegu_style_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cegu_req_t;

endpackage : cegu_pkg

`default_nettype wire

// >>> core/cegu_gain_ramp.sv
`timescale 1ns/10ps
`default_nettype none

module cegu_gain_ramp
  import cegu_pkg::*;
(
  input  wire logic              core_clk,   // System clock.
  input  wire logic              resetn,     // Async reset, active low.
  input  wire logic              load,       // New target gain written.
  input  wire logic [GAIN_W-1:0] target,     // Target gain, 0.5 dB units.
  input  wire cegu_style_t       style,      // Style latched with the load.
  output logic      [GAIN_W-1:0] gain,       // Applied gain.
  output logic                   busy        // Change in progress.
);

  // ---------------------------------------------------------------------------
  // Step pacing
  // ---------------------------------------------------------------------------
  typedef enum {CEGU_IDLE, CEGU_WAIT, CEGU_STEP} cegu_ramp_state_t;

  cegu_ramp_state_t  state, next_state;
  cegu_style_t       act_style, next_act_style;
  logic [GAIN_W-1:0] goal, next_goal, next_gain;
  logic [11:0]       cnt, next_cnt;

  // Pacing interval per style; smooth mode waits once then jumps.
  function automatic logic [11:0] interval(input cegu_style_t s);
    case (s)
      CEGU_STYLE_RAMP_FAST: interval = 12'(STEP_FAST_CYC - 1);
      CEGU_STYLE_RAMP_SLOW: interval = 12'(STEP_SLOW_CYC - 1);
      default:              interval = 12'(SMOOTH_CYC - 1);
    endcase
  endfunction : interval

  // Next-state logic; a new load restarts from the current gain.
  always_comb begin
    next_state     = state;
    next_act_style = act_style;
    next_goal      = goal;
    next_gain      = gain;
    next_cnt       = cnt;
    if (load) begin
      next_act_style = style;                                 // see R14
      next_goal      = target;
      if (style == CEGU_STYLE_IMMEDIATE) begin
        next_gain  = target;                                  // see R01
        next_state = CEGU_IDLE;
      end else begin
        next_cnt   = interval(style);
        next_state = CEGU_WAIT;
      end
    end else begin
      case (state)
        CEGU_IDLE: next_cnt = '0;
        CEGU_WAIT: begin
          if (cnt == '0) begin
            next_state = CEGU_STEP;
          end else begin
            next_cnt = cnt - 12'h001;
          end
        end
        CEGU_STEP: begin
          if (act_style == CEGU_STYLE_SMOOTH) begin
            next_gain  = goal;                                // see R02
            next_state = CEGU_IDLE;
          end else if (gain == goal) begin
            next_state = CEGU_IDLE;
          end else begin
            // One 0.5 dB step per interval.
            if (gain < goal) begin
              next_gain = gain + 7'h01;                       // see R03
            end else begin
              next_gain = gain - 7'h01;                       // see R04
            end
            next_cnt   = interval(act_style);
            next_state = (next_gain == goal) ? CEGU_IDLE : CEGU_WAIT;
          end
        end
        default: next_state = CEGU_IDLE;
      endcase
    end
  end

  // State registers.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state     <= CEGU_IDLE;
      act_style <= CEGU_STYLE_IMMEDIATE;
      goal      <= '0;
      gain      <= '0;
      cnt       <= '0;
      busy      <= 1'b0;
    end else begin
      state     <= next_state;
      act_style <= next_act_style;
      goal      <= next_goal;
      gain      <= next_gain;
      cnt       <= next_cnt;
      busy      <= (next_state != CEGU_IDLE);
    end
  end

endmodule : cegu_gain_ramp

`default_nettype wire

// >>> core/cegu_cfg.sv
// Functional notes
// R01 - Style code 0 applies a new channel gain at once.
// R02 - Style code 1 applies gain with artifact reduction, no stepping.
// R03 - Style code 2 ramps gain in 0.5 dB steps every 20 us.
// R04 - Style code 3 ramps gain in 0.5 dB steps every 40 us.
// R05 - Host keeps ramped gain within 30 dB or 24 dB by input mode.
// R06 - Input gate bit 7 enables channel 1, resets to one.
// R07 - Input gate bit 6 enables channel 2, resets to one.
// R08 - Input gate bit 5 enables microphone channel 3, resets to zero.
// R09 - Input gate bit 4 enables microphone channel 4, resets to zero.
// R10 - Output gate bits 7..4 drive or tri-state slots 1 to 4.
// R11 - Output gate resets to zero, so no slot drives.
// R12 - Host writes only reset values into reserved bits.
// R13 - Power-up bit powers enabled channels; clear powers all down.
// R14 - Style in force at a gain write governs that gain change.
`timescale 1ns/10ps
`default_nettype none

module cegu_cfg
  import cegu_pkg::*;
(
  input  wire logic              core_clk,        // System clock.
  input  wire logic              resetn,          // Async reset, active low.
  input  wire cegu_req_t         req,             // Register access request.
  output logic      [7:0]        rdata,           // Read data, registered.
  output logic                   rvalid,          // Read data valid pulse.
  input  wire logic [1:0]        gain_load,       // Gain write per channel.
  input  wire logic [GAIN_W-1:0] gain_target,     // Written gain value.
  output logic [1:0][GAIN_W-1:0] gain_applied,    // Applied gain per channel.
  output logic      [1:0]        gain_busy,       // Change in progress.
  output logic      [3:0]        lane_power,      // Channel power request.
  output logic      [3:0]        slot_drive_oe,   // Slot output enables.
  output logic      [1:0]        live_gain_update_style // Current style.
);

  // ---------------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------------
  logic [7:0] gain_update_style_config, next_gain_update_style_config;
  logic [7:0] input_channel_gate, next_input_channel_gate;
  logic [7:0] output_slot_gate, next_output_slot_gate;
  logic [7:0] power_control, next_power_control;
  logic [7:0] next_rdata;

  // Merge writable bits with reserved ones held at reset value.
  function automatic logic [7:0] merge(input logic [7:0] d,
                                       input logic [7:0] m,
                                       input logic [7:0] r);
    merge = (d & m) | (r & ~m);
  endfunction : merge

  // Writes and reads. Reserved bits ignore the host so a careless
  // write cannot disturb hidden state.
  always_comb begin
    next_gain_update_style_config = gain_update_style_config;
    next_input_channel_gate       = input_channel_gate;
    next_output_slot_gate         = output_slot_gate;
    next_power_control            = power_control;
    next_rdata                    = rdata;
    if (req.wr) begin
      case (req.addr)
        GAIN_UPDATE_STYLE_CONFIG_OFS: next_gain_update_style_config =
          merge(req.wdata, GAIN_UPDATE_STYLE_WMASK,
                GAIN_UPDATE_STYLE_CONFIG_RST);                // see R12
        INPUT_CHANNEL_GATE_OFS: next_input_channel_gate =
          merge(req.wdata, CHANNEL_GATE_WMASK,
                INPUT_CHANNEL_GATE_RST);                      // see R06
        OUTPUT_SLOT_GATE_OFS: next_output_slot_gate =
          merge(req.wdata, CHANNEL_GATE_WMASK,
                OUTPUT_SLOT_GATE_RST);                        // see R10
        POWER_CONTROL_OFS: next_power_control =
          merge(req.wdata, POWER_CONTROL_WMASK, POWER_CONTROL_RST);
        default: ;
      endcase
    end
    if (req.rd) begin
      case (req.addr)
        GAIN_UPDATE_STYLE_CONFIG_OFS: next_rdata = gain_update_style_config;
        INPUT_CHANNEL_GATE_OFS:       next_rdata = input_channel_gate;
        OUTPUT_SLOT_GATE_OFS:         next_rdata = output_slot_gate;
        POWER_CONTROL_OFS:            next_rdata = power_control;
        default:                      next_rdata = 8'h00;
      endcase
    end
  end

  // Register state; reset values give channels 1 and 2 enabled.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gain_update_style_config <= GAIN_UPDATE_STYLE_CONFIG_RST;
      input_channel_gate       <= INPUT_CHANNEL_GATE_RST;   // see R07
      output_slot_gate         <= OUTPUT_SLOT_GATE_RST;     // see R11
      power_control            <= POWER_CONTROL_RST;
      rdata                    <= 8'h00;
      rvalid                   <= 1'b0;
    end else begin
      gain_update_style_config <= next_gain_update_style_config;
      input_channel_gate       <= next_input_channel_gate;
      output_slot_gate         <= next_output_slot_gate;
      power_control            <= next_power_control;
      rdata                    <= next_rdata;
      rvalid                   <= req.rd;
    end
  end

  // ---------------------------------------------------------------------------
  // Channel power and slot drive
  // ---------------------------------------------------------------------------
  logic [3:0] next_lane_power, next_slot_drive_oe;

  // Bit 7 maps to channel 1, so the field is reversed into lane order.
  // Channels 3 and 4 gate microphone lanes only.
  always_comb begin
    next_lane_power    = 4'h0;
    next_slot_drive_oe = 4'h0;
    for (int i = 0; i < 4; i++) begin
      next_lane_power[i] = power_control[POWER_UP_BIT] &
                           input_channel_gate[7-i];           // see R13
      next_slot_drive_oe[i] = output_slot_gate[7-i];          // see R10
    end
  end

  // Registered so outputs come straight from flops (one cycle lag).
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lane_power             <= 4'h0;
      slot_drive_oe          <= 4'h0;
      live_gain_update_style <= 2'h0;
    end else begin
      lane_power             <= next_lane_power;  // see R08 see R09
      slot_drive_oe          <= next_slot_drive_oe;
      live_gain_update_style <=
        gain_update_style_config[STYLE_LSB+1:STYLE_LSB];
    end
  end

  // ---------------------------------------------------------------------------
  // Per-channel gain update engines
  // ---------------------------------------------------------------------------
  cegu_style_t cur_style;
  assign cur_style =
    cegu_style_t'(gain_update_style_config[STYLE_LSB+1:STYLE_LSB]);

  // The style is sampled at the gain write; later style writes leave
  // an ongoing ramp alone so the audio never sees a glitch.
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ramp
      cegu_gain_ramp u_ramp (
        .core_clk (core_clk),
        .resetn   (resetn),
        .load     (gain_load[ch]),                            // see R14
        .target   (gain_target),
        .style    (cur_style),
        .gain     (gain_applied[ch]),
        .busy     (gain_busy[ch])
      );
    end
  endgenerate

endmodule : cegu_cfg

`default_nettype wire

// >>> sim/cegu_host.sv
`timescale 1ns/10ps
`default_nettype none
module cegu_host
  import cegu_pkg::*;
(
  input  wire logic       core_clk, // System clock.
  output var  cegu_req_t  req,      // Request to the block.
  input  wire logic [7:0] rdata,    // Read data.
  input  wire logic       rvalid    // Read data valid.
);
  // A released bus shows inverted values so stale data never matches.
  initial req = '{1'b0, 1'b0, 8'hFF, 8'hFF};
  // The caller passes reset values in reserved bits.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk) req <= '{1'b0, 1'b0, ~a, ~d};
  endtask : wr
  // The answer is registered at the taking edge and read 1 ns later.
  task automatic rd(input logic [7:0] a, output logic [8:0] q);
    @(posedge core_clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk) req <= '{1'b0, 1'b0, ~a, 8'hFF};
    #1 q = {rvalid, rdata};
  endtask : rd
endmodule : cegu_host
`default_nettype wire

// >>> sim/cegu_cfg_chk.sv
`timescale 1ns/10ps
`default_nettype none
module cegu_cfg_chk
  import cegu_pkg::*;
(
  input wire logic                  core_clk,     // System clock.
  input wire logic                  resetn,       // Async reset.
  input wire cegu_req_t             req,          // Request.
  input wire logic [7:0]            rdata,        // Read data.
  input wire logic                  rvalid,       // Read valid.
  input wire logic [1:0]            gain_load,    // Gain writes.
  input wire logic [GAIN_W-1:0]     gain_target,  // Gain value.
  input wire logic [1:0][GAIN_W-1:0] gain_applied, // Applied gains.
  input wire logic [1:0]            gain_busy,    // Change active.
  input wire logic [3:0]            lane_power,   // Power request.
  input wire logic [3:0]            slot_drive_oe, // Slot enables.
  input wire logic [1:0]            live_gain_update_style // Style.
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  int unsigned gap;
  // Cycles since the last gain event; ramp pacing is judged against it.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) gap <= 0;
    else if (gain_load[0] || $changed(gain_applied[0])) gap <= 0;
    else gap <= gap + 1;
  end
  a_read_answer: assert property (req.rd |=> rvalid)
    else $error("read not answered");
  a_read_cause: assert property (rvalid |-> $past(req.rd))
    else $error("spurious read valid");
  a_unmapped_zero: assert property (req.rd && !(req.addr inside
    {8'h71, 8'h73, 8'h74, 8'h75}) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_slot_follow: assert property (req.wr && req.addr == 8'h74
    |-> ##2 slot_drive_oe == {$past(req.wdata[4], 2), $past(req.wdata[5], 2),
    $past(req.wdata[6], 2), $past(req.wdata[7], 2)})
    else $error("slot enables do not follow write");
  a_style_follow: assert property (req.wr && req.addr == 8'h71
    |-> ##2 live_gain_update_style == $past(req.wdata[7:6], 2))
    else $error("style does not follow write");
  a_power_cause: assert property ($changed(lane_power)
    |-> $past(req.wr, 2)) else $error("power changed unprompted");
  a_gain_now: assert property (gain_load[0] &&
    live_gain_update_style == 2'h0 |=> !gain_busy[0] &&
    gain_applied[0] == $past(gain_target)) else $error("gain not at once");
  a_smooth_busy: assert property (gain_load[0] &&
    live_gain_update_style == 2'h1 && gain_target != gain_applied[0]
    |=> gain_busy[0]) else $error("smooth change not started");
  a_ramp_unit: assert property (live_gain_update_style[1] &&
    $past(gain_busy[0]) && $changed(gain_applied[0]) |->
    (gain_applied[0] - $past(gain_applied[0])) inside {7'h01, 7'h7F})
    else $error("ramp step not one unit");
  a_ramp_fast: assert property (live_gain_update_style == 2'h2 &&
    $past(gain_busy[0]) && $changed(gain_applied[0]) |->
    gap inside {[990:1010]}) else $error("fast ramp pace wrong");
  a_ramp_slow: assert property (live_gain_update_style == 2'h3 &&
    $past(gain_busy[0]) && $changed(gain_applied[0]) |->
    gap inside {[1990:2010]}) else $error("slow ramp pace wrong");
endmodule : cegu_cfg_chk
bind cegu_cfg cegu_cfg_chk i_cegu_cfg_chk (
  .core_clk(core_clk), .resetn(resetn), .req(req), .rdata(rdata),
  .rvalid(rvalid), .gain_load(gain_load), .gain_target(gain_target),
  .gain_applied(gain_applied), .gain_busy(gain_busy),
  .lane_power(lane_power), .slot_drive_oe(slot_drive_oe),
  .live_gain_update_style(live_gain_update_style));
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
  import cegu_pkg::*;
;
  logic core_clk, resetn;
  cegu_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  logic [1:0] gain_load, gain_busy, live_gain_update_style;
  logic [GAIN_W-1:0] gain_target;
  logic [1:0][GAIN_W-1:0] gain_applied;
  logic [3:0] lane_power, slot_drive_oe;
  logic [8:0] q;
  int error_cnt, checks_done, cyc;
  cegu_cfg i_cegu_cfg (.core_clk(core_clk), .resetn(resetn), .req(req),
    .rdata(rdata), .rvalid(rvalid), .gain_load(gain_load),
    .gain_target(gain_target), .gain_applied(gain_applied),
    .gain_busy(gain_busy), .lane_power(lane_power),
    .slot_drive_oe(slot_drive_oe),
    .live_gain_update_style(live_gain_update_style));
  cegu_host i_cegu_host (.core_clk(core_clk), .req(req), .rdata(rdata),
    .rvalid(rvalid));
  task automatic check(string what, logic [8:0] seen, logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // Outputs follow a taken write one edge after the register.
  task automatic settle();
    @(posedge core_clk);
    #1;
  endtask : settle
  task automatic t_reset();
    logic [7:0] a [4] = '{8'h71, 8'h73, 8'h74, 8'h75};
    logic [7:0] r [4] = '{8'h00, 8'hC0, 8'h00, 8'h00};
    for (int i = 0; i < 4; i++) begin
      i_cegu_host.rd(a[i], q);
      check("reset value", q, {1'b1, r[i]});
    end
    check("slots at reset", slot_drive_oe, 9'h0);
  endtask : t_reset
  // Unmapped places read as zero and ignore writes.
  task automatic t_unmapped();
    i_cegu_host.rd(8'h72, q);
    check("unmapped read", q, 9'h100);
    i_cegu_host.wr(8'h72, 8'hFF);
    i_cegu_host.rd(8'h73, q);
    check("gate kept", q, 9'h1C0);
  endtask : t_unmapped
  task automatic t_input();
    i_cegu_host.wr(8'h75, 8'h40);
    settle();
    check("lanes 1 2", lane_power, 9'h3);
    i_cegu_host.wr(8'h73, 8'hA0);
    settle();
    check("lanes 1 3", lane_power, 9'h5);
    i_cegu_host.wr(8'h73, 8'h50);
    settle();
    check("lanes 2 4", lane_power, 9'hA);
    i_cegu_host.wr(8'h75, 8'h00);
    settle();
    check("lanes off", lane_power, 9'h0);
  endtask : t_input
  task automatic t_slots();
    for (int i = 0; i < 5; i++) begin
      // The last pass clears every slot; reserved bits stay at zero.
      i_cegu_host.wr(8'h74, 8'hF0 & (8'h80 >> i));
      settle();
      check("slot drive", slot_drive_oe, {5'h00, 4'(4'h1 << i)});
    end
  endtask : t_slots
  // Both channels load; the wait measures how long the change takes.
  task automatic t_gain(logic [1:0] s, logic [6:0] t, int lo, int hi);
    int n;
    n = 0;
    i_cegu_host.wr(8'h71, {s, 6'h00});
    settle();
    check("style", live_gain_update_style, s);
    @(posedge core_clk) {gain_load, gain_target} <= {2'b11, t};
    @(posedge core_clk) gain_load <= 2'b00;
    #1;
    while (gain_busy !== 2'b00 && n < 5000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("gain 1", gain_applied[0], t);
    check("gain 2", gain_applied[1], t);
    check("duration", n >= lo && n <= hi, 9'h1);
  endtask : t_gain
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // A hang counts as a mismatch and ends the run.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    resetn = 1'b0;
    gain_load = 2'b00;
    gain_target = '0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_unmapped();
    t_input();
    t_slots();
    t_gain(2'h0, 7'd10, 0, 0);
    t_gain(2'h1, 7'd20, 1, SMOOTH_CYC + 2);
    t_gain(2'h2, 7'd22, 2 * STEP_FAST_CYC, 2 * STEP_FAST_CYC + 10);
    t_gain(2'h3, 7'd20, 2 * STEP_SLOW_CYC, 2 * STEP_SLOW_CYC + 10);
    conclude();
  end
endmodule : tb
`default_nettype wire
